// [logic/biphase_pkg.sv]
// Operation
// (RULE1) tx preamble lasts 1 to 15 bit times; length 0 sends none
// (RULE2) tx preamble pattern: ones, zeros, one-zero or zero-one, length separately set
// (RULE3) default polarity: zero is low-to-high, one is high-to-low mid-cell
// (RULE4) delimiter_select 1 sends encoded zero; 0 sends three-bit-time sync
// (RULE5) command sync: high one and a half bits, then low one and a half
// (RULE6) next_char_kind 1 precedes character with command sync, 0 with data sync
// (RULE7) per-character enable takes sync kind from holding register kind bit
// (RULE8) drift compensation only at 16x and only when enabled
// (RULE9) edge within one sample clock of expected is jitter, no change
// (RULE10) edge 2-4 early shortens period by one; 2-3 late lengthens by one
// (RULE11) async receive oversamples 16x at rate select 0, 8x at 1
// (RULE12) start after 8th (16x) or 4th (8x) low sample; bits every 16/8
// (RULE13) receiver uses transmitter's length, nine-bit, order and parity settings
// (RULE14) receiver checks one stop bit only, then hunts next start at once
// (RULE15) codec enable turns on preamble and delimiter detection on rx line
// (RULE16) rx preamble length, pattern, polarity independent; length 0 disables detection
// (RULE17) decoder shares delimiter_select: 1 accepts encoded zero, 0 accepts sync
// (RULE18) start after quarter bit low with short-pulse rejection; sample at 1/4, 3/4
// (RULE19) valid preamble or delimiter keeps alignment; mismatch realigns on next edge
// (RULE20) missing mid-cell transition sets sticky violation flag until clear command; code sets it for data cells only, not the parity cell
// (RULE21) sync mode stores received character with kind bit: 1 command, 0 data
// (RULE22) remote transmitter starts each frame's first bit low-to-high
// (RULE23) polarity one inverts mapping: one sent as low-to-high
// (RULE24) data sync is complement of command sync: low then high
package biphase_pkg;
	localparam int ADDR_W = 8;
	// register offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] MODE_OFS = 8'h04;
	localparam logic [7:0] CFG_OFS  = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0c;
	localparam logic [7:0] THR_OFS  = 8'h10;
	localparam logic [7:0] RHR_OFS  = 8'h14;
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam logic [31:0] CFG_RST  = 32'h0000_0000;
	localparam logic [1:0] RESP_OK  = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;
	// field positions
	localparam int CLR_BIT   = 0;
	localparam int CHAR_LENGTH_LSB  = 0;
	localparam int NINE_BIT  = 2;
	localparam int ORDER_BIT = 3;
	localparam int PAR_LSB   = 4;
	localparam int STOP_LSB  = 7;
	localparam int SRATE_BIT = 9;
	localparam int CLKD_BIT  = 10;
	localparam int DELIM_BIT = 11;
	localparam int KIND_BIT  = 12;
	localparam int VKIND_BIT = 13;
	localparam int CODEC_BIT = 14;
	localparam int TXLEN_LSB = 0;
	localparam int TXPAT_LSB = 8;
	localparam int TXPOL_BIT = 12;
	localparam int RXLEN_LSB = 16;
	localparam int RXPAT_LSB = 24;
	localparam int RXPOL_BIT = 28;
	localparam int DRIFT_BIT = 30;
	localparam int HKIND_BIT = 12;
	localparam int RXRDY_BIT = 0;
	localparam int TXRDY_BIT = 1;
	localparam int VIOL_BIT  = 2;
	// timing in sampling clocks
	localparam logic [2:0] QTR16 = 3'd4;
	localparam logic [2:0] QTR8  = 3'd2;
	localparam logic [3:0] JIT_LO = 4'd3;
	localparam logic [3:0] EARLY_HI = 4'd2;
	localparam logic [3:0] LATE_LO = 4'd6;
	localparam logic [3:0] LATE_HI = 4'd7;
	localparam logic [2:0] SYNC_LAST = 3'd5;
	// encodings
	localparam logic [1:0] LEAD_ONES = 2'd0;
	localparam logic [1:0] LEAD_ZEROS = 2'd1;
	localparam logic [1:0] LEAD_ONE_ZERO = 2'd2;
	localparam logic [2:0] PAR_EVEN = 3'd0;
	localparam logic [2:0] PAR_ODD = 3'd1;
	localparam logic [2:0] PAR_SPACE = 3'd2;
	typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_DELIM, TX_DATA, TX_PAR} tx_state_t;
	typedef enum logic [2:0] {DC_HUNT, DC_LEAD, DC_DELIM, DC_DATA, DC_PAR} dc_state_t;
	typedef enum logic [1:0] {NZ_HUNT, NZ_DATA, NZ_PAR, NZ_STOP} nz_state_t;

	function automatic logic lead_bit(input logic [1:0] pat, input logic [3:0] idx);
		if (pat == LEAD_ONES) return 1'b1;
		else if (pat == LEAD_ZEROS) return 1'b0;
		else if (pat == LEAD_ONE_ZERO) return ~idx[0];
		else return idx[0];
	endfunction : lead_bit

	function automatic logic [3:0] bit_pos(input logic [3:0] n, input logic [3:0] idx,
			input logic msb);
		return msb ? n - 4'd1 - idx : idx;
	endfunction : bit_pos

	function automatic logic par_of(input logic [8:0] d, input logic [8:0] m,
			input logic [2:0] md);
		if (md == PAR_EVEN) return ^(d & m);
		else if (md == PAR_ODD) return ~^(d & m);
		else return md != PAR_SPACE;
	endfunction : par_of
endpackage : biphase_pkg

// [logic/biphase_usart_codec_async_rx.sv]
module biphase_usart_codec_async_rx (
	input  wire logic                           ref_clk_i,
	input  wire logic                           rst_i,
	input  wire logic                           sample_tick_i,
	input  wire logic                           rx_line_i,
	output logic                                tx_line_o,
	input  wire logic [biphase_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                           s_axi_awvalid_i,
	output logic                                s_axi_awready_o,
	input  wire logic [31:0]                    s_axi_wdata_i,
	input  wire logic [3:0]                     s_axi_wstrb_i,
	input  wire logic                           s_axi_wvalid_i,
	output logic                                s_axi_wready_o,
	output logic [1:0]                          s_axi_bresp_o,
	output logic                                s_axi_bvalid_o,
	input  wire logic                           s_axi_bready_i,
	input  wire logic [biphase_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic                           s_axi_arvalid_i,
	output logic                                s_axi_arready_o,
	output logic [31:0]                         s_axi_rdata_o,
	output logic [1:0]                          s_axi_rresp_o,
	output logic                                s_axi_rvalid_o,
	input  wire logic                           s_axi_rready_i
);
	import biphase_pkg::*;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	logic [31:0] mode_q, cfg_q, wmask, rd_val;
	logic        wr_go, rd_go, rd_ok, wr_ok, clr_cmd, thr_wr, rhr_rd;
	logic        rx_s1_q, rxs, codec_en, delim_one, over8, drift_on, par_on;
	logic [2:0]  q_len;
	logic [3:0]  half_len, nbits;
	logic [4:0]  bit_len;
	logic [8:0]  cmask;

	// settings shared by both directions
	assign codec_en  = mode_q[CODEC_BIT];
	assign delim_one = mode_q[DELIM_BIT];
	// (RULE11) oversampling rate
	assign over8     = mode_q[SRATE_BIT];
	assign q_len     = over8 ? QTR8 : QTR16;
	assign half_len  = {q_len, 1'b0};
	assign bit_len   = {q_len, 2'b00};
	// (RULE13) shared character format
	assign nbits     = mode_q[NINE_BIT] ? 4'd9 : 4'd5 + {2'b00, mode_q[CHAR_LENGTH_LSB +: 2]};
	assign cmask     = ~(9'h1ff << nbits);
	assign par_on    = ~mode_q[PAR_LSB + 2];
	// (RULE8) drift logic gated
	assign drift_on  = cfg_q[DRIFT_BIT] & ~over8;

	// the line is asynchronous: two flops before any use
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_s1_q <= 1'b1;
			rxs     <= 1'b1;
		end else begin
			rx_s1_q <= rx_line_i;
			rxs     <= rx_s1_q;
		end
	end

	// bus slave: write address and data are taken together
	assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o;
	assign rd_go = s_axi_arvalid_i & ~s_axi_rvalid_o;
	assign s_axi_awready_o = wr_go;
	assign s_axi_wready_o  = wr_go;
	assign s_axi_arready_o = rd_go;
	assign wmask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
		{8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
	assign clr_cmd = wr_go && s_axi_awaddr_i == CTRL_OFS && s_axi_wstrb_i[0]
		&& s_axi_wdata_i[CLR_BIT];
	assign thr_wr  = wr_go && s_axi_awaddr_i == THR_OFS;
	assign rhr_rd  = rd_go && s_axi_araddr_i == RHR_OFS;
	assign wr_ok   = s_axi_awaddr_i == CTRL_OFS || s_axi_awaddr_i == MODE_OFS
		|| s_axi_awaddr_i == CFG_OFS || s_axi_awaddr_i == THR_OFS;

	// configuration registers honour byte strobes
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_q <= MODE_RST;
			cfg_q  <= CFG_RST;
		end else if (wr_go && s_axi_awaddr_i == MODE_OFS) begin
			mode_q <= (mode_q & ~wmask) | (s_axi_wdata_i & wmask);
		end else if (wr_go && s_axi_awaddr_i == CFG_OFS) begin
			cfg_q <= (cfg_q & ~wmask) | (s_axi_wdata_i & wmask);
		end
	end

	// write response; unmapped or read-only offsets answer with an error
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OK;
		end else if (wr_go) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_ok ? RESP_OK : RESP_ERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ---------------- transmitter ----------------
	tx_state_t   tx_st_q;
	logic [3:0]  tx_tick_q, tx_idx_q, tx_lead_len;
	logic [2:0]  tx_half_q, half_last;
	logic [8:0]  tx_shift_q, thr_q;
	logic        thr_kind_q, tx_kind_q, txrdy_q, tx_pol, tx_bit, tx_lvl;
	logic        tx_load, tx_elem_end, tx_stage_end;

	assign tx_lead_len = cfg_q[TXLEN_LSB +: 4];
	assign tx_pol = cfg_q[TXPOL_BIT];
	assign tx_load = tx_st_q == TX_IDLE && !txrdy_q && codec_en;
	assign half_last = (tx_st_q == TX_DELIM && !delim_one) ? SYNC_LAST : 3'd1;
	assign tx_elem_end = sample_tick_i && tx_tick_q == half_len - 4'd1
		&& tx_half_q == half_last;
	assign tx_stage_end = tx_elem_end && ((tx_st_q == TX_LEAD && tx_idx_q == tx_lead_len - 4'd1)
		|| (tx_st_q == TX_DATA && tx_idx_q == nbits - 4'd1)
		|| tx_st_q == TX_DELIM || tx_st_q == TX_PAR);

	// holding register; a write while full is dropped
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			txrdy_q <= 1'b1;
			thr_q <= 9'h000;
			thr_kind_q <= 1'b0;
		end else if (thr_wr && txrdy_q) begin
			txrdy_q <= 1'b0;
			thr_q <= (thr_q & ~wmask[8:0]) | (s_axi_wdata_i[8:0] & wmask[8:0]);
			thr_kind_q <= s_axi_wdata_i[HKIND_BIT];
		end else if (tx_load) begin
			txrdy_q <= 1'b1;
		end
	end

	// frame sequencer: preamble, delimiter, data, optional parity
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_st_q <= TX_IDLE;
			tx_shift_q <= 9'h000;
			tx_kind_q <= 1'b0;
		end else if (tx_load) begin
			tx_shift_q <= thr_q;
			// (RULE6) (RULE7) sync kind source
			tx_kind_q <= mode_q[VKIND_BIT] ? thr_kind_q : mode_q[KIND_BIT];
			// (RULE1) zero length skips preamble
			tx_st_q <= (tx_lead_len != 4'd0) ? TX_LEAD : TX_DELIM;
		end else if (tx_stage_end) begin
			case (tx_st_q)
				TX_LEAD: tx_st_q <= TX_DELIM;
				TX_DELIM: tx_st_q <= TX_DATA;
				TX_DATA: tx_st_q <= par_on ? TX_PAR : TX_IDLE;
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// half-cell timing
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_tick_q <= 4'd0;
			tx_half_q <= 3'd0;
			tx_idx_q <= 4'd0;
		end else if (tx_st_q == TX_IDLE) begin
			tx_tick_q <= 4'd0;
			tx_half_q <= 3'd0;
			tx_idx_q <= 4'd0;
		end else if (sample_tick_i) begin
			tx_tick_q <= (tx_tick_q == half_len - 4'd1) ? 4'd0 : tx_tick_q + 4'd1;
			if (tx_tick_q == half_len - 4'd1)
				tx_half_q <= (tx_half_q == half_last) ? 3'd0 : tx_half_q + 3'd1;
			if (tx_stage_end)
				tx_idx_q <= 4'd0;
			else if (tx_elem_end)
				tx_idx_q <= tx_idx_q + 4'd1;
		end
	end

	// line level; idle high so at polarity 0 the first zero cell starts with a falling edge
	always_comb begin
		tx_bit = 1'b0;
		case (tx_st_q)
			// (RULE2) preamble pattern
			TX_LEAD: tx_bit = lead_bit(cfg_q[TXPAT_LSB +: 2], tx_idx_q);
			TX_DATA: tx_bit = tx_shift_q[bit_pos(nbits, tx_idx_q, mode_q[ORDER_BIT])];
			TX_PAR: tx_bit = par_of(tx_shift_q, cmask, mode_q[PAR_LSB +: 3]);
			default: tx_bit = 1'b0;
		endcase
		// (RULE3) (RULE23) first half is bit xor polarity
		tx_lvl = (tx_bit ^ tx_pol) ^ tx_half_q[0];
		if (tx_st_q == TX_IDLE)
			tx_lvl = 1'b1;
		// (RULE4) (RULE5) (RULE24) sync shapes
		else if (tx_st_q == TX_DELIM && !delim_one)
			tx_lvl = tx_kind_q ^ (tx_half_q >= 3'd3);
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) tx_line_o <= 1'b1;
		else tx_line_o <= tx_lvl;
	end

	lead_len_zero_a: assert property (tx_st_q == TX_LEAD |-> tx_lead_len != 4'd0) // (RULE1)
		else $error("preamble sent with zero length");
	cmd_sync_a: assert property ((tx_st_q == TX_DELIM && !delim_one && tx_kind_q // (RULE5)
		&& tx_half_q < 3'd3) |=> tx_line_o) else $error("command sync not high");
	data_sync_a: assert property ((tx_st_q == TX_DELIM && !delim_one && !tx_kind_q // (RULE24)
		&& tx_half_q < 3'd3) |=> !tx_line_o) else $error("data sync not low");
	manch_map_a: assert property ((tx_st_q == TX_DATA && !tx_half_q[0]) |=> // (RULE3)
		tx_line_o == $past(tx_bit ^ tx_pol)) else $error("wrong cell mapping");
	delimiter_select_delim_a: assert property ((tx_st_q == TX_DELIM && delim_one) |=> // (RULE4)
		tx_line_o == $past(tx_pol ^ tx_half_q[0])) else $error("bad one-bit delimiter");
	cmd_sync_c: cover property (tx_st_q == TX_DELIM && !delim_one && tx_kind_q);

	// ---------------- biphase decoder ----------------
	dc_state_t   dc_st_q;
	logic [4:0]  dc_cnt_q;
	logic [3:0]  dc_low_q, dc_idx_q, dc_el_q, dc_pos_q, rx_lead_len;
	logic [8:0]  dc_shift_q, dc_word;
	logic        dc_half_q, dc_s1_q, dc_seen_q, dc_cmd_q, dc_dat_q;
	logic        dc_samp, dc_bit, dc_viol, dc_cmd_n, dc_dat_n, dc_done, dc_err;
	logic        dc_short, dc_long, dc_start;
	logic [1:0]  cmd_pat;

	assign rx_lead_len = cfg_q[RXLEN_LSB +: 4];
	// (RULE18) quarter-bit low with rejection of shorter pulses
	assign dc_start = codec_en && dc_st_q == DC_HUNT && sample_tick_i && !rxs
		&& dc_low_q == {1'b0, q_len} - 4'd1;
	assign dc_samp = sample_tick_i && dc_st_q != DC_HUNT && dc_cnt_q == 5'd0;
	assign dc_bit  = dc_s1_q ^ cfg_q[RXPOL_BIT];
	assign dc_viol = dc_samp && dc_half_q && dc_s1_q == rxs;
	assign cmd_pat = (dc_idx_q == 4'd0) ? 2'b11 : (dc_idx_q == 4'd1) ? 2'b10 : 2'b00;
	assign dc_cmd_n = dc_cmd_q && {dc_s1_q, rxs} == cmd_pat;
	assign dc_dat_n = dc_dat_q && {dc_s1_q, rxs} == ~cmd_pat;
	// (RULE9) (RULE10) classify the mid-cell edge
	assign dc_short = drift_on && dc_seen_q && dc_pos_q <= EARLY_HI;
	assign dc_long  = drift_on && dc_seen_q && dc_pos_q >= LATE_LO && dc_pos_q <= LATE_HI;
	// (RULE19) mismatch before data drops alignment
	always_comb begin
		dc_err = 1'b0;
		if (dc_st_q == DC_LEAD)
			dc_err = dc_s1_q == rxs || dc_bit != lead_bit(cfg_q[RXPAT_LSB +: 2], dc_idx_q);
		else if (dc_st_q == DC_DELIM && delim_one)
			dc_err = dc_s1_q == rxs || dc_bit;
		else if (dc_st_q == DC_DELIM)
			dc_err = !(dc_cmd_n || dc_dat_n);
	end
	assign dc_done = dc_samp && dc_half_q && ((dc_st_q == DC_DATA && dc_idx_q == nbits - 4'd1
		&& !par_on) || dc_st_q == DC_PAR);

	// the last data bit is never written to the shifter when done ends the data phase, so merge it here
	always_comb begin
		dc_word = dc_shift_q;
		if (dc_st_q == DC_DATA)
			dc_word[bit_pos(nbits, dc_idx_q, mode_q[ORDER_BIT])] = dc_bit;
	end

	// hunt counter: consecutive low samples, cleared by any high sample; parked at all
	// ones after a frame so a trailing low half cell cannot pass for a new start
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) dc_low_q <= 4'd0;
		else if (dc_st_q != DC_HUNT) dc_low_q <= 4'hf;
		else if (dc_start || (sample_tick_i && rxs)) dc_low_q <= 4'd0;
		else if (sample_tick_i && dc_low_q != 4'hf) dc_low_q <= dc_low_q + 4'd1;
	end

	// sample timing and edge position within the second quarter pair
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dc_cnt_q <= 5'd0;
			dc_half_q <= 1'b0;
			dc_s1_q <= 1'b0;
			dc_el_q <= 4'd0;
			dc_seen_q <= 1'b0;
			dc_pos_q <= 4'd0;
		end else if (dc_start || (dc_samp && !dc_half_q)) begin
			// quarter-cell sample
			dc_s1_q <= rxs;
			dc_half_q <= 1'b1;
			dc_cnt_q <= {1'b0, half_len} - 5'd1;
			dc_el_q <= 4'd1;
			dc_seen_q <= 1'b0;
		end else if (dc_samp) begin
			// (RULE10) adjust the period after the three-quarter sample
			dc_half_q <= 1'b0;
			dc_cnt_q <= {1'b0, half_len} - 5'd1 - {4'd0, dc_short} + {4'd0, dc_long};
		end else if (sample_tick_i && dc_st_q != DC_HUNT) begin
			dc_cnt_q <= dc_cnt_q - 5'd1;
			dc_el_q <= dc_el_q + 4'd1;
			if (dc_half_q && !dc_seen_q && rxs != dc_s1_q) begin
				dc_seen_q <= 1'b1;
				dc_pos_q <= dc_el_q;
			end
		end
	end

	// (RULE15) (RULE16) (RULE17) preamble, delimiter and data phases
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dc_st_q <= DC_HUNT;
			dc_idx_q <= 4'd0;
			dc_cmd_q <= 1'b1;
			dc_dat_q <= 1'b1;
			dc_shift_q <= 9'h000;
		end else if (!codec_en) begin
			dc_st_q <= DC_HUNT;
		end else if (dc_start) begin
			dc_st_q <= (rx_lead_len != 4'd0) ? DC_LEAD : DC_DELIM;
			dc_idx_q <= 4'd0;
			dc_cmd_q <= 1'b1;
			dc_dat_q <= 1'b1;
			dc_shift_q <= 9'h000;
		end else if (dc_samp && dc_half_q) begin
			dc_idx_q <= dc_idx_q + 4'd1;
			if (dc_err || dc_done) begin
				dc_st_q <= DC_HUNT;
			end else if (dc_st_q == DC_LEAD) begin
				if (dc_idx_q == rx_lead_len - 4'd1) begin
					dc_st_q <= DC_DELIM;
					dc_idx_q <= 4'd0;
				end
			end else if (dc_st_q == DC_DELIM) begin
				dc_cmd_q <= dc_cmd_n;
				dc_dat_q <= dc_dat_n;
				if (delim_one || dc_idx_q == 4'd2) begin
					dc_st_q <= DC_DATA;
					dc_idx_q <= 4'd0;
				end
			end else if (dc_st_q == DC_DATA) begin
				dc_shift_q[bit_pos(nbits, dc_idx_q, mode_q[ORDER_BIT])] <= dc_bit;
				if (dc_idx_q == nbits - 4'd1) dc_st_q <= DC_PAR;
			end
		end
	end

	drift_gate_a: assert property ((dc_short || dc_long) |-> // (RULE8)
		cfg_q[DRIFT_BIT] && !over8) else $error("drift adjust outside 16x enable");
	jitter_a: assert property ((dc_seen_q && dc_pos_q >= JIT_LO // (RULE9)
		&& dc_pos_q <= LATE_LO - 4'd1) |-> !(dc_short || dc_long))
		else $error("jitter treated as drift");
	realign_a: assert property ((dc_samp && dc_half_q && dc_err) |=> // (RULE19)
		dc_st_q == DC_HUNT) else $error("no realign after mismatch");
	dc_done_c: cover property (dc_done && !delim_one && dc_cmd_q);
	dc_viol_c: cover property (dc_viol && dc_st_q == DC_DATA);

	// ---------------- asynchronous NRZ receiver ----------------
	nz_state_t   nz_st_q;
	logic [4:0]  nz_cnt_q;
	logic [3:0]  nz_low_q, nz_idx_q;
	logic [8:0]  nz_shift_q;
	logic        nz_en, nz_samp, nz_start, nz_done;

	assign nz_en = !codec_en && !mode_q[CLKD_BIT];
	// (RULE12) start at the half-bit low sample
	assign nz_start = nz_en && nz_st_q == NZ_HUNT && sample_tick_i && !rxs
		&& nz_low_q == {q_len, 1'b0} - 4'd1;
	assign nz_samp = sample_tick_i && nz_st_q != NZ_HUNT && nz_cnt_q == 5'd0;
	assign nz_done = nz_samp && nz_st_q == NZ_STOP;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) nz_low_q <= 4'd0;
		else if (nz_st_q != NZ_HUNT || nz_start || (sample_tick_i && rxs)) nz_low_q <= 4'd0;
		else if (sample_tick_i) nz_low_q <= nz_low_q + 4'd1;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			nz_st_q <= NZ_HUNT;
			nz_cnt_q <= 5'd0;
			nz_idx_q <= 4'd0;
			nz_shift_q <= 9'h000;
		end else if (!nz_en) begin
			nz_st_q <= NZ_HUNT;
		end else if (nz_start) begin
			nz_st_q <= NZ_DATA;
			nz_cnt_q <= bit_len - 5'd1;
			nz_idx_q <= 4'd0;
			nz_shift_q <= 9'h000;
		end else if (nz_samp) begin
			nz_cnt_q <= bit_len - 5'd1;
			case (nz_st_q)
				NZ_DATA: begin
					nz_shift_q[bit_pos(nbits, nz_idx_q, mode_q[ORDER_BIT])] <= rxs;
					nz_idx_q <= nz_idx_q + 4'd1;
					if (nz_idx_q == nbits - 4'd1) nz_st_q <= par_on ? NZ_PAR : NZ_STOP;
				end
				NZ_PAR: nz_st_q <= NZ_STOP;
				// (RULE14) one stop bit, then hunt
				default: nz_st_q <= NZ_HUNT;
			endcase
		end else if (sample_tick_i && nz_st_q != NZ_HUNT) begin
			nz_cnt_q <= nz_cnt_q - 5'd1;
		end
	end

	stop_hunt_a: assert property (nz_done |=> nz_st_q == NZ_HUNT) // (RULE14)
		else $error("receiver did not hunt after stop");
	nrz_start_a: assert property ((nz_st_q == NZ_HUNT) ##1 (nz_st_q == NZ_DATA) |-> // (RULE12)
		$past(rxs) == 1'b0 && nz_cnt_q == bit_len - 5'd1) else $error("bad start");
	nz_done_c: cover property (nz_done && over8);

	// ---------------- holding and status ----------------
	logic [8:0] rhr_q;
	logic       rhr_kind_q, rxrdy_q, viol_q;

	// (RULE21) store character with its sync kind
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rhr_q <= 9'h000;
			rhr_kind_q <= 1'b0;
		end else if (dc_done) begin
			rhr_q <= dc_word;
			rhr_kind_q <= !delim_one && dc_cmd_q;
		end else if (nz_done) begin
			rhr_q <= nz_shift_q;
			rhr_kind_q <= 1'b0;
		end
	end

	// sticky flags: a new event beats a clear in the same cycle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rxrdy_q <= 1'b0;
			viol_q <= 1'b0;
		end else begin
			rxrdy_q <= dc_done || nz_done || (rxrdy_q && !rhr_rd);
			// (RULE20) violation held until clear
			viol_q <= (dc_viol && dc_st_q == DC_DATA) || (viol_q && !clr_cmd);
		end
	end

	viol_sticky_a: assert property ((viol_q && !clr_cmd) |=> viol_q) // (RULE20)
		else $error("violation flag lost");

	// read mux
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b1;
		if (s_axi_araddr_i == MODE_OFS) rd_val = mode_q;
		else if (s_axi_araddr_i == CFG_OFS) rd_val = cfg_q;
		else if (s_axi_araddr_i == STAT_OFS) begin
			rd_val[RXRDY_BIT] = rxrdy_q;
			rd_val[TXRDY_BIT] = txrdy_q && codec_en;
			rd_val[VIOL_BIT] = viol_q;
		end else if (s_axi_araddr_i == RHR_OFS) begin
			rd_val[8:0] = rhr_q;
			rd_val[HKIND_BIT] = rhr_kind_q;
		end else if (s_axi_araddr_i != CTRL_OFS && s_axi_araddr_i != THR_OFS) rd_ok = 1'b0;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= RESP_OK;
		end else if (rd_go) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_val;
			s_axi_rresp_o <= rd_ok ? RESP_OK : RESP_ERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end
endmodule : biphase_usart_codec_async_rx

// [test/remote_peer.sv]
module remote_peer (
	input  wire logic ref_clk_i,
	input  wire logic sample_tick_i,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle high between frames, as an unloaded serial line sits
	initial line_o = 1'b1;
	// levels change only at a tick edge and are held for whole half cells
	task automatic hold(input logic v, input int n);
		line_o <= v;
		repeat (n) @(posedge ref_clk_i iff sample_tick_i);
	endtask : hold
	// kind 0 encoded-zero start, 1 data sync, 2 plain start bit, 3 zero cell then
	// command sync; bad flattens cell 2
	task automatic send(input int kind, input logic [7:0] d, input logic bad);
		if (kind == 0 || kind == 3) begin
			hold(1'b0, 8);
			hold(1'b1, 8);
		end
		if (kind == 3) begin
			hold(1'b1, 24);
			hold(1'b0, 24);
		end
		if (kind == 1) begin
			hold(1'b0, 24);
			hold(1'b1, 24);
		end
		if (kind == 2) begin
			hold(1'b0, 16);
		end
		for (int i = 0; i < 8; i++) begin
			if (kind == 2 || (bad && i == 2)) begin
				hold(d[i], 16);
			end else begin
				hold(d[i], 8);
				hold(~d[i], 8);
			end
		end
		// one stop bit, so plain frames run back to back
		hold(1'b1, 16);
	endtask : send
endmodule : remote_peer

// [test/biphase_usart_codec_async_rx_test.sv]
module biphase_usart_codec_async_rx_test;
	timeunit 1ns;
	timeprecision 1ps;
	import biphase_pkg::*;
	logic        ref_clk_i, rst_i, sample_tick_i, rx_line_i, tx_line_o;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, got;
	logic [3:0]  s_axi_wstrb_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
	logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	int          bad_count, total_checks, cyc;
	int          exp_q[$];
	logic [31:0] cfgs [4]  = '{32'h0, 32'h1203, 32'h0, 32'h0};
	logic [31:0] modes [4] = '{32'h4843, 32'h5043, 32'h6043, 32'h4043};
	biphase_usart_codec_async_rx dut (.*);
	remote_peer peer (.ref_clk_i, .sample_tick_i, .line_o(rx_line_i));
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// tick every second clock keeps frames short; cycle ceiling cuts a hang
	always @(posedge ref_clk_i) begin
		sample_tick_i <= ~sample_tick_i;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do @(posedge ref_clk_i); while (s_axi_awready_o !== 1'b1);
		s_axi_awvalid_i <= 1'b0;
		s_axi_wvalid_i <= 1'b0;
		while (s_axi_bvalid_o !== 1'b1) @(posedge ref_clk_i);
		resp = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge ref_clk_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		while (s_axi_rvalid_o !== 1'b1) @(posedge ref_clk_i);
		got = s_axi_rdata_o;
		resp = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask : rd
	// model builds the half-cell levels, then samples mid half on the line
	task automatic tx_run(input int t);
		logic [7:0] d;
		int e[$];
		int b, pol, k;
		d = 8'($urandom);
		pol = cfgs[t][12];
		k = modes[t][13] ? 1 : modes[t][12];
		for (int i = 0; i < cfgs[t][3:0]; i++) begin
			b = cfgs[t][9:8] == 2'd0 ? 1 : cfgs[t][9:8] == 2'd1 ? 0 : (i + cfgs[t][8] + 1) % 2;
			e.push_back(b ^ pol);
			e.push_back(!(b ^ pol));
		end
		if (modes[t][11]) begin
			e.push_back(0);
			e.push_back(1);
		end else begin
			for (int i = 0; i < 6; i++) e.push_back(i < 3 ? k : !k);
		end
		for (int i = 0; i < 8; i++) begin
			e.push_back(d[i] ^ pol);
			e.push_back(!(d[i] ^ pol));
		end
		// idle high hides leading high halves, so align on the first low one
		while (e[0] == 1) void'(e.pop_front());
		while (tx_line_o !== 1'b1) @(posedge ref_clk_i);
		wr(CFG_OFS, cfgs[t]);
		wr(MODE_OFS, modes[t]);
		wr(THR_OFS, {19'h0, 1'b1, 4'h0, d});
		while (tx_line_o !== 1'b0) @(posedge ref_clk_i);
		repeat (4) @(posedge ref_clk_i iff sample_tick_i);
		foreach (e[i]) begin
			chk({31'h0, tx_line_o}, e[i]);
			repeat (8) @(posedge ref_clk_i iff sample_tick_i);
		end
	endtask : tx_run
	// kind 2 sends two plain frames back to back; the later one overwrites
	task automatic rx_one(input logic [31:0] mode, input int kind, input logic bad);
		wr(MODE_OFS, mode);
		repeat (kind == 2 ? 2 : 1) begin
			exp_q.push_back(8'($urandom));
			peer.send(kind, 8'(exp_q[$]), bad);
		end
		do rd(STAT_OFS); while (got[RXRDY_BIT] !== 1'b1);
		chk({31'h0, got[VIOL_BIT]}, {31'h0, bad});
		rd(RHR_OFS);
		while (exp_q.size() > 1) void'(exp_q.pop_front());
		if (!bad) chk(got, exp_q[0] + (kind == 3 ? 1 << HKIND_BIT : 0));
		void'(exp_q.pop_front());
	endtask : rx_one
	task automatic finish_test();
		if (bad_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	initial begin
		rst_i = 1'b1;
		sample_tick_i = 1'b0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
		s_axi_wstrb_i = 4'hf;
		void'($urandom(64310));
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		rd(CFG_OFS);
		chk(got, CFG_RST);
		rd(8'h1c);
		chk({30'h0, resp}, {30'h0, RESP_ERR});
		wr(STAT_OFS, 32'h4);
		chk({30'h0, resp}, {30'h0, RESP_ERR});
		for (int t = 0; t < 4; t++) tx_run(t);
		wr(CFG_OFS, 32'h0);
		rx_one(32'h4843, 0, 1'b0);
		rx_one(32'h4043, 1, 1'b0);
		rx_one(32'h4843, 0, 1'b1);
		wr(CTRL_OFS, 32'h1);
		rx_one(32'h0043, 2, 1'b0);
		wr(CFG_OFS, 32'h0101_0000);
		rx_one(32'h4043, 3, 1'b0);
		finish_test();
	end
endmodule : biphase_usart_codec_async_rx_test
